/* rtl/plac_core.sv */
`timescale 1ns/1ps
`default_nettype none
module plac_core import plac_pkg::*; #(
  parameter int NUM_BANKS = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NUM_BANKS < 1 || NUM_BANKS > 2) begin : g_chk
    $error("NUM_BANKS must be 1 or 2");
  end

  // ----------------------------------------
  // Permission maps
  // ----------------------------------------
  // Bit 4 is locality 4 down to bit 0 for locality 0
  function automatic logic [4:0] reset_mask(input logic [4:0] i);
    if (i == 5'h10 || i == 5'h17) begin
      reset_mask = 5'h0F; // RULE16
    end else if (i >= 5'h11 && i <= 5'h13) begin
      reset_mask = 5'h10; // RULE16
    end else if (i >= 5'h14 && i <= 5'h16) begin
      reset_mask = 5'h1C; // RULE16
    end else begin
      reset_mask = 5'h00; // RULE16
    end
  endfunction

  // Clear column equals the mask below locality 4
  function automatic logic clear_ok(input logic [4:0] i, input logic [2:0] l);
    logic [4:0] m;
    m = reset_mask(i);
    clear_ok = (l < 3'h4) && m[l[1:0]]; // RULE10 RULE11
  endfunction

  function automatic logic ext_ok(input logic [4:0] i, input logic [2:0] l);
    logic [4:0] m;
    m = 5'h1F;
    if (i == 5'h11 || i == 5'h12) begin
      m = 5'h1C;
    end else if (i == 5'h13) begin
      m = 5'h0C;
    end else if (i == 5'h14) begin
      m = 5'h0E;
    end else if (i == 5'h15 || i == 5'h16) begin
      m = 5'h04;
    end
    ext_ok = (l <= 3'h4) && m[l]; // RULE14
  endfunction

  function automatic logic no_counter(input logic [4:0] i);
    no_counter = (i == 5'h10) || (i >= 5'h15 && i <= 5'h17); // RULE17
  endfunction

  // Locality-4 mask bit picks the all-ones start
  function automatic logic [DIG_W-1:0] init_val(input logic [4:0] i, input logic [2:0] l);
    logic [4:0] m;
    m = reset_mask(i);
    if (i == PCR_ROOT) begin
      init_val = {{(DIG_W-3){1'b0}}, l}; // RULE21
    end else if (m[4]) begin
      init_val = '1; // RULE18 RULE20
    end else begin
      init_val = '0;
    end
  endfunction

  function automatic logic alg_ok(input logic [15:0] a);
    alg_ok = (a == ALG_SHA256) || (a == ALG_SHA384); // RULE3
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Flip-flop store: volatile, no wear hazard
  logic [DIG_W-1:0] pcr_q [NUM_BANKS][NUM_PCR]; // RULE1 RULE6 RULE19
  logic [15:0] alg_q [NUM_BANKS];
  plac_cmd_s cmd_q;
  logic cmd_go_q;
  logic [31:0] data_q;
  logic [5:0] rsel_q;
  logic [1:0] err_q;
  logic [7:0] done_cnt_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic setup;
  logic acc;
  logic [31:0] rd_d;
  logic map_hit;
  logic bank_ok;
  logic [4:0] attr_m;

  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign bank_ok = (int'(cmd_q.bank) < NUM_BANKS);
  assign attr_m = reset_mask(rsel_q[4:0]);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb begin
    map_hit = 1'b1;
    rd_d = '0;
    unique case (paddr)
      OFS_CMD: rd_d = {20'h00000, cmd_q};
      OFS_DATA: rd_d = data_q;
      OFS_STAT: rd_d = {22'h000000, done_cnt_q, err_q};
      OFS_RSEL: rd_d = {26'h0000000, rsel_q};
      OFS_RVAL: begin
        if (int'(rsel_q[5]) < NUM_BANKS && rsel_q[4:0] < 5'h18) begin
          rd_d = pcr_q[rsel_q[5]][rsel_q[4:0]];
        end
      end
      OFS_ATTR: begin
        // Auth value and policy bits stay zero: empty, not settable
        rd_d = {23'h000000, 1'b0, 1'b0, (rsel_q[4:0] < 5'h10),
                no_counter(rsel_q[4:0]), attr_m}; // RULE7 RULE16 RULE17
      end
      OFS_ALG: rd_d = {alg_q[NUM_BANKS-1], alg_q[0]};
      default: map_hit = 1'b0;
    endcase
  end

  // No wait state: pready is high in the first access cycle, answer taken on the access edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !map_hit;
        prdata_q <= pwrite ? 32'h00000000 : rd_d;
      end
    end
  end

  // ----------------------------------------
  // Command and operand registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q <= '0;
      cmd_go_q <= 1'b0;
      data_q <= '0;
      rsel_q <= '0;
    end else begin
      cmd_go_q <= acc && pwrite && paddr == OFS_CMD;
      if (acc && pwrite) begin
        unique case (paddr)
          OFS_CMD: cmd_q <= plac_cmd_s'(pwdata[11:0]);
          OFS_DATA: data_q <= pwdata;
          OFS_RSEL: rsel_q <= pwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Command outcome
  // ----------------------------------------
  logic [1:0] res;
  always_comb begin
    res = ERR_OK;
    if (cmd_q.loc > 3'h4 || !bank_ok) begin
      res = ERR_BADVAL; // RULE22
    end else begin
      unique case (cmd_q.op)
        OP_CLEAR: begin
          if (cmd_q.idx >= 5'h18 || !clear_ok(cmd_q.idx, cmd_q.loc)) begin
            res = ERR_DENIED; // RULE11 RULE23
          end
        end
        OP_EXTEND, OP_EVENT: begin
          if (cmd_q.idx >= 5'h18 || !ext_ok(cmd_q.idx, cmd_q.loc)) begin
            res = ERR_DENIED; // RULE15 RULE23
          end
        end
        OP_LAUNCH: begin
          if (cmd_q.loc != LAUNCH_LOC[2:0]) begin
            res = ERR_DENIED; // RULE12
          end
        end
        OP_SETPOL, OP_SETAUTH: res = ERR_BADVAL; // RULE8
        OP_ALLOC: begin
          if (!alg_ok(data_q[15:0])) begin
            res = ERR_BADVAL;
          end else if (data_q[20:16] < 5'h18) begin
            res = ERR_NORES; // RULE2
          end
        end
        OP_STARTUP: res = ERR_OK;
      endcase
    end
  end

  // Status counter lets software see each completion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      err_q <= ERR_OK;
      done_cnt_q <= '0;
    end else if (cmd_go_q) begin
      err_q <= res; // RULE23
      done_cnt_q <= done_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Bank hash selection
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        alg_q[b] <= (b == 1) ? ALG_SHA384 : ALG_SHA256; // RULE4 RULE5
      end
    end else if (cmd_go_q && cmd_q.op == OP_ALLOC && res == ERR_OK) begin
      alg_q[cmd_q.bank] <= data_q[15:0]; // RULE4 RULE6
    end
  end

  // ----------------------------------------
  // Measurement register store
  // ----------------------------------------
  // Extend result comes from the outside hash engine via the operand
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < NUM_PCR; i++) begin
          pcr_q[b][i] <= init_val(5'(i), 3'h0);
        end
      end
    end else if (cmd_go_q && res == ERR_OK) begin
      unique case (cmd_q.op)
        OP_STARTUP: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            for (int i = 0; i < NUM_PCR; i++) begin
              pcr_q[b][i] <= init_val(5'(i), cmd_q.loc); // RULE21
            end
          end
        end
        OP_CLEAR: pcr_q[cmd_q.bank][cmd_q.idx] <= '0; // RULE10
        OP_EXTEND, OP_EVENT: pcr_q[cmd_q.bank][cmd_q.idx] <= data_q; // RULE14
        OP_LAUNCH: begin
          // Launch register 17 is zeroed here and left at zero; this branch does not extend it
          for (int b = 0; b < NUM_BANKS; b++) begin
            for (int i = 0; i < NUM_PCR; i++) begin
              // Locality-4 mask bit alone marks the launch-cleared set
              if ((reset_mask(5'(i)) & 5'h10) != 5'h00) begin
                pcr_q[b][i] <= '0; // RULE9 RULE12 RULE13 RULE18
              end
            end
          end
        end
        default: ;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_cmd(plac_op_e o, logic [4:0] i, logic [2:0] l);
    cmd_go_q && cmd_q.op == o && cmd_q.idx == i && cmd_q.loc == l && cmd_q.bank == 1'b0;
  endsequence

  property p_clr_low;
    s_cmd(OP_CLEAR, 5'h05, 3'h0) |=> err_q == ERR_DENIED && $stable(pcr_q[0][5]);
  endproperty
  a_clr_low: assert property (p_clr_low) else $error("low register cleared"); // RULE11

  property p_clr_dbg;
    s_cmd(OP_CLEAR, 5'h10, 3'h3) |=> pcr_q[0][16] == '0 && err_q == ERR_OK;
  endproperty
  a_clr_dbg: assert property (p_clr_dbg) else $error("register 16 not cleared"); // RULE10

  property p_clr_20;
    s_cmd(OP_CLEAR, 5'h14, 3'h1) |=> err_q == ERR_DENIED && $stable(pcr_q[0][20]);
  endproperty
  a_clr_20: assert property (p_clr_20) else $error("20 cleared at locality 1"); // RULE10

  property p_launch;
    s_cmd(OP_LAUNCH, cmd_q.idx, 3'h4) |=> pcr_q[0][17] == '0 && pcr_q[0][22] == '0;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not zero"); // RULE12

  property p_launch_keep;
    cmd_go_q && cmd_q.op == OP_LAUNCH |=> $stable(pcr_q[0][16]) && $stable(pcr_q[0][23]);
  endproperty
  a_launch_keep: assert property (p_launch_keep) else $error("launch touched 16/23"); // RULE13

  property p_launch_low;
    cmd_go_q && cmd_q.op == OP_LAUNCH && cmd_q.loc == 3'h3 |=> $stable(pcr_q[0][18]);
  endproperty
  a_launch_low: assert property (p_launch_low) else $error("low launch reset 18"); // RULE12

  property p_ext_21;
    s_cmd(OP_EXTEND, 5'h15, 3'h2) |=> pcr_q[0][21] == $past(data_q);
  endproperty
  a_ext_21: assert property (p_ext_21) else $error("extend 21 lost"); // RULE14

  property p_ext_deny;
    s_cmd(OP_EVENT, 5'h13, 3'h4) |=> $stable(pcr_q[0][19]) ##0 err_q == ERR_DENIED;
  endproperty
  a_ext_deny: assert property (p_ext_deny) else $error("event 19 at loc 4 allowed"); // RULE15

  property p_setpol;
    cmd_go_q && (cmd_q.op == OP_SETPOL || cmd_q.op == OP_SETAUTH) |=> err_q == ERR_BADVAL;
  endproperty
  a_setpol: assert property (p_setpol) else $error("auth change not refused"); // RULE8

  property p_startup;
    s_cmd(OP_STARTUP, cmd_q.idx, cmd_q.loc) ##0 cmd_q.loc <= 3'h4
      |=> pcr_q[0][0] == DIG_W'($past(cmd_q.loc)) && pcr_q[0][17] == '1;
  endproperty
  a_startup: assert property (p_startup) else $error("startup init wrong"); // RULE21

  property p_alg_def;
    $fell(reset) |-> alg_q[0] == ALG_SHA256;
  endproperty
  a_alg_def: assert property (@(posedge ref_clk) p_alg_def) else $error("default hash wrong"); // RULE4

  property p_apb;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");

  property p_ext_18_low;
    s_cmd(OP_EXTEND, 5'h12, 3'h1) |=> err_q == ERR_DENIED && $stable(pcr_q[0][18]);
  endproperty
  a_ext_18_low: assert property (p_ext_18_low) else $error("extend 18 at loc 1 allowed"); // RULE15

  property p_clr_17;
    s_cmd(OP_CLEAR, 5'h11, 3'h3) |=> err_q == ERR_DENIED && $stable(pcr_q[0][17]);
  endproperty
  a_clr_17: assert property (p_clr_17) else $error("register 17 cleared"); // RULE11

  property p_clr_23;
    s_cmd(OP_CLEAR, 5'h17, 3'h0) |=> pcr_q[0][23] == '0 && err_q == ERR_OK;
  endproperty
  a_clr_23: assert property (p_clr_23) else $error("register 23 not cleared"); // RULE10

  property p_launch_root;
    cmd_go_q && cmd_q.op == OP_LAUNCH |=> $stable(pcr_q[0][0]);
  endproperty
  a_launch_root: assert property (p_launch_root) else $error("launch touched 0"); // RULE13

  property p_bad_loc;
    cmd_go_q && cmd_q.loc > 3'h4 |=> err_q == ERR_BADVAL;
  endproperty
  a_bad_loc: assert property (p_bad_loc) else $error("bad locality accepted"); // RULE22

  // Short allocation must leave the bank hash as it was
  property p_alloc_short;
    cmd_go_q && cmd_q.op == OP_ALLOC && cmd_q.bank == 1'b0 && data_q[20:16] < 5'h18
      |=> err_q != ERR_OK && $stable(alg_q[0]);
  endproperty
  a_alloc_short: assert property (p_alloc_short) else $error("short allocation taken"); // RULE2
endmodule
`default_nettype wire

/* rtl/plac_pkg.sv */
// Operation
// (RULE1) Each bank holds measurement registers 0-23; more than one bank allowed.
// (RULE2) Allocation of fewer than 24 registers may be refused with no_result_code.
// (RULE3) Banks support hash identifiers 0x000C and 0x000B.
// (RULE4) Single bank defaults to 0x000B and may be reallocated to any supported hash.
// (RULE5) Multiple banks enable both mandatory hashes by default.
// (RULE6) Registers 0-23 exist in every bank for any hash combination.
// (RULE7) Authorization value and policy are empty and fixed for every register.
// (RULE8) set_policy_command and set_auth_command return bad_value_code, change nothing.
// (RULE9) Register 17 is the dynamic launch register, register 0 the static root one.
// (RULE10) Clear 16 and 23 from localities 0-3; 20-22 from localities 2-3.
// (RULE11) Never clear 0-15 or 17-19; never clear from a locality not allowed.
// (RULE12) Launch at locality 4 resets 17-22; lower localities reset none.
// (RULE13) Launch leaves registers 0-16 and 23 unchanged.
// (RULE14) Extend permissions per register and locality as the fixed map gives.
// (RULE15) Extend or event from a forbidden locality leaves the register alone.
// (RULE16) Capability query returns the five-bit locality reset mask per register.
// (RULE17) Only 0-15 preserved across resume; no-counter set for 16, 21-23.
// (RULE18) Locality-4 mask bit gives initial all-ones state and launch zeroing.
// (RULE19) Registers live in volatile storage.
// (RULE20) Minus one means a digest word with every bit set.
// (RULE21) Clearing startup loads register 0 with the startup locality.
// (RULE22) Host gives each command a valid locality 0-4.
// (RULE23) Rejected clear or extend reports an error and changes nothing.
package plac_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RSEL = 8'h0C;
  localparam logic [7:0] OFS_RVAL = 8'h10;
  localparam logic [7:0] OFS_ATTR = 8'h14;
  localparam logic [7:0] OFS_ALG = 8'h18;
  // ----------------------------------------
  // Fields and values
  // ----------------------------------------
  localparam int NUM_PCR = 24;
  localparam int DIG_W = 32;
  localparam logic [15:0] ALG_SHA256 = 16'h000B;
  localparam logic [15:0] ALG_SHA384 = 16'h000C;
  localparam logic [4:0] LAUNCH_LOC = 5'h04;
  localparam logic [4:0] PCR_LAUNCH = 5'h11;
  localparam logic [4:0] PCR_ROOT = 5'h00;
  localparam logic [1:0] ERR_OK = 2'h0;
  localparam logic [1:0] ERR_BADVAL = 2'h1;
  localparam logic [1:0] ERR_NORES = 2'h2;
  localparam logic [1:0] ERR_DENIED = 2'h3;

  typedef enum logic [2:0] {
    OP_STARTUP, OP_CLEAR, OP_EXTEND, OP_EVENT,
    OP_LAUNCH, OP_SETPOL, OP_SETAUTH, OP_ALLOC
  } plac_op_e;

  // CMD word: [2:0] op, [7:3] index, [10:8] locality, [11] bank
  typedef struct packed {
    logic bank;
    logic [2:0] loc;
    logic [4:0] idx;
    plac_op_e op;
  } plac_cmd_s;
endpackage

/* bench/plac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module plac_host import plac_pkg::*; (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // No wait bound here: a stuck slave is cut short by the bench watchdog
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input plac_op_e op, input int i, input int l, input logic b,
                     input logic [31:0] d);
    plac_cmd_s c;
    logic [31:0] rd;
    logic err;
    c = '{bank: b, loc: 3'(l), idx: 5'(i), op: op};
    xfer(1'b1, OFS_DATA, d, rd, err);
    xfer(1'b1, OFS_CMD, {20'h00000, c}, rd, err);
  endtask
endmodule
`default_nettype wire

/* bench/pcr_locality_access_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pcr_locality_access_control_bench import plac_pkg::*;;
  logic ref_clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int err_count;
  int samples_checked;
  plac_core #(.NUM_BANKS(2)) u_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  plac_host u_host (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    u_host.xfer(1'b0, a, 32'h00000000, d, e);
  endtask
  task automatic pv(input int i, input logic b, input logic [31:0] x);
    logic [31:0] d;
    logic e;
    u_host.xfer(1'b1, OFS_RSEL, {26'h0000000, b, 5'(i)}, d, e);
    rd(OFS_RVAL, d);
    chk("pcr value", d, x);
  endtask
  task automatic st(input logic [1:0] x);
    logic [31:0] d;
    rd(OFS_STAT, d);
    chk("status", {30'h00000000, d[1:0]}, {30'h00000000, x});
  endtask
  // Locality 4 down to 0; clear rights are the low four bits
  function automatic logic [4:0] rmask(input int i);
    if (i == 16 || i == 23) return 5'h0F;
    if (i > 16 && i < 20) return 5'h10;
    if (i > 19) return 5'h1C;
    return 5'h00;
  endfunction
  function automatic logic [4:0] emap(input int i);
    if (i == 17 || i == 18) return 5'h1C;
    if (i == 19) return 5'h0C;
    if (i == 20) return 5'h0E;
    if (i == 21 || i == 22) return 5'h04;
    return 5'h1F;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_init();
    logic [31:0] d;
    logic [4:0] m;
    rd(OFS_ALG, d);
    chk("alg", d, {ALG_SHA384, ALG_SHA256});
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < NUM_PCR; i++) begin
        m = rmask(i);
        pv(i, 1'(b), m[4] ? 32'hFFFFFFFF : 32'h00000000);
        rd(OFS_ATTR, d);
        chk("attr", d, {25'h0000000, 1'(i < 16), 1'(i == 16 || i > 20), m});
      end
    end
  endtask
  task automatic t_clear();
    logic [4:0] m;
    for (int i = 0; i < NUM_PCR; i++) begin
      m = rmask(i) & 5'h0F;
      for (int l = 0; l < 5; l++) begin
        u_host.cmd(OP_EXTEND, i, 2, 1'b0, 32'hA5A50000 + i);
        u_host.cmd(OP_CLEAR, i, l, 1'b0, 32'h00000000);
        st(m[l] ? ERR_OK : ERR_DENIED);
        pv(i, 1'b0, m[l] ? 32'h00000000 : 32'hA5A50000 + i);
      end
    end
  endtask
  // Locality 2 may extend every register, so it seeds a known value first
  task automatic t_ext();
    logic [4:0] m;
    plac_op_e op;
    for (int k = 0; k < 4; k++) begin
      op = k[0] ? OP_EVENT : OP_EXTEND;
      for (int i = 0; i < NUM_PCR; i++) begin
        m = emap(i);
        for (int l = 0; l < 5; l++) begin
          u_host.cmd(OP_EXTEND, i, 2, k[1], 32'h11110000 + i);
          u_host.cmd(op, i, l, k[1], 32'h22220000 + l);
          st(m[l] ? ERR_OK : ERR_DENIED);
          pv(i, k[1], m[l] ? 32'h22220000 + l : 32'h11110000 + i);
        end
      end
    end
  endtask
  task automatic t_launch();
    for (int i = 0; i < NUM_PCR; i++) u_host.cmd(OP_EXTEND, i, 2, 1'b0, 32'h33330000 + i);
    u_host.cmd(OP_LAUNCH, 0, 3, 1'b0, 32'h00000000);
    st(ERR_DENIED);
    pv(18, 1'b0, 32'h33330012);
    u_host.cmd(OP_LAUNCH, 0, 4, 1'b0, 32'h00000000);
    st(ERR_OK);
    for (int i = 0; i < NUM_PCR; i++) begin
      pv(i, 1'b0, (i > 16 && i < 23) ? 32'h00000000 : 32'h33330000 + i);
    end
  endtask
  task automatic t_misc();
    logic [31:0] d;
    logic e;
    u_host.cmd(OP_SETPOL, 5, 0, 1'b0, 32'hFFFFFFFF);
    st(ERR_BADVAL);
    u_host.cmd(OP_SETAUTH, 5, 0, 1'b0, 32'hFFFFFFFF);
    st(ERR_BADVAL);
    pv(5, 1'b0, 32'h33330005);
    rd(OFS_ATTR, d);
    chk("auth", d & 32'h00000180, 32'h00000000);
    u_host.cmd(OP_CLEAR, 16, 5, 1'b0, 32'h00000000);
    st(ERR_BADVAL);
    u_host.xfer(1'b0, 8'h40, 32'h00000000, d, e);
    chk("unmapped err", {31'h00000000, e}, 32'h00000001);
    chk("unmapped data", d, 32'h00000000);
    u_host.cmd(OP_STARTUP, 0, 3, 1'b0, 32'h00000000);
    pv(0, 1'b0, 32'h00000003);
    pv(5, 1'b0, 32'h00000000);
    pv(20, 1'b0, 32'hFFFFFFFF);
    u_host.cmd(OP_ALLOC, 0, 0, 1'b0, {11'h000, 5'h17, ALG_SHA384});
    st(ERR_NORES);
    u_host.cmd(OP_ALLOC, 0, 0, 1'b0, {11'h000, 5'h18, 16'h0005});
    st(ERR_BADVAL);
    u_host.cmd(OP_ALLOC, 0, 0, 1'b0, {11'h000, 5'h18, ALG_SHA384});
    st(ERR_OK);
    rd(OFS_ALG, d);
    chk("alg", d, {ALG_SHA384, ALG_SHA384});
    u_host.cmd(OP_ALLOC, 0, 0, 1'b0, {11'h000, 5'h18, ALG_SHA256});
    rd(OFS_ALG, d);
    chk("alg", d, {ALG_SHA384, ALG_SHA256});
  endtask
  // ----------------------------------------
  // Clock, reset and verdict
  // ----------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    err_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_init();
    t_clear();
    t_ext();
    t_launch();
    t_misc();
    tally_and_finish();
  end
  // Full run is near 13k cycles; stop at 50k so a hang cannot drag on
  initial begin
    #250000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
